/* File: ssf_pkg.sv */
// ****************************************************************
// shared constants of the sprite shape fetch block
// ****************************************************************
package ssf_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_SPR = 8;
  localparam int SPR_W = 3;
  localparam int ROW_W = 5;
  localparam int COLOR_W = 4;
  localparam int ROW_BYTES = 3;
  localparam logic [ROW_W-1:0] SPR_ROWS = 5'h15;
  localparam logic [4:0] SC_DOTS = 5'h18;
  localparam logic [4:0] MC_DOTS = 5'h0c;
  localparam int BLOCK_SHIFT = 6;
  localparam int BANK_SHIFT = 14;
  localparam int SCREEN_SHIFT = 10;
  localparam logic [9:0] PTR_AREA_OFS = 10'h3f8;
  localparam logic [1:0] ROM_WINDOW = 2'h1;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] REG_ENABLE = 16'hd015;
  localparam logic [ADDR_W-1:0] REG_VDOUBLE = 16'hd017;
  localparam logic [ADDR_W-1:0] REG_MCSELECT = 16'hd01c;
  localparam logic [ADDR_W-1:0] REG_HDOUBLE = 16'hd01d;
  localparam logic [ADDR_W-1:0] REG_SHARED0 = 16'hd025;
  localparam logic [ADDR_W-1:0] REG_SHARED1 = 16'hd026;
  localparam logic [ADDR_W-1:0] REG_COLOR_BASE = 16'hd027;
  localparam logic [ADDR_W-1:0] REG_SCREEN = 16'hd040;
  localparam logic [ADDR_W-1:0] REG_BANK = 16'hd041;
  localparam logic [ADDR_W-1:0] REG_STATUS = 16'hd042;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_BITS = 8'h00;
  localparam logic [COLOR_W-1:0] RST_COLOR = 4'h0;
  localparam logic [3:0] RST_SCREEN = 4'h1;
  localparam logic [1:0] RST_BANK = 2'h0;

  // ****************************************************************
  // dot codes
  // ****************************************************************
  localparam logic [1:0] CODE_CLEAR = 2'h0;
  localparam logic [1:0] CODE_SHARED0 = 2'h1;
  localparam logic [1:0] CODE_OWN = 2'h2;
  localparam logic [1:0] CODE_SHARED1 = 2'h3;

  typedef enum logic [2:0] {
    FS_IDLE, FS_PTR, FS_PTR_WAIT, FS_DATA, FS_DATA_WAIT, FS_LOAD_RD, FS_LOAD_WR
  } ssf_fetch_state_t;

endpackage

/* File: ssf_line_buf.sv */
`timescale 1ns/1ps
// ****************************************************************
// one shape row per sprite, byte writes, whole-row registered read
// ****************************************************************
module ssf_line_buf (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic wr_en_in,
  input wire logic [ssf_pkg::SPR_W-1:0] wr_spr_in,
  input wire logic [1:0] wr_byte_in,
  input wire logic [ssf_pkg::DATA_W-1:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [ssf_pkg::SPR_W-1:0] rd_spr_in,
  output logic [3*ssf_pkg::DATA_W-1:0] rd_row_out
);
  import ssf_pkg::*;

  typedef struct packed {
    logic [NUM_SPR-1:0][ROW_BYTES-1:0][DATA_W-1:0] mem;
    logic [3*DATA_W-1:0] rd_row;
  } ssf_buf_state_t;

  ssf_buf_state_t st;
  ssf_buf_state_t next_st;

  always_comb begin
    next_st = st;
    if (wr_en_in) begin
      next_st.mem[wr_spr_in][wr_byte_in] = wr_data_in;
    end
    // byte 0 lands in the top bits: leftmost dots first
    if (rd_en_in) begin
      next_st.rd_row = {st.mem[rd_spr_in][0], st.mem[rd_spr_in][1], st.mem[rd_spr_in][2]}; // [R1]
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_row_out = st.rd_row;
endmodule

/* File: ssf_dot_shifter.sv */
`timescale 1ns/1ps
// ****************************************************************
// per sprite dot serialiser with width doubling and color decode
// ****************************************************************
module ssf_dot_shifter (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic load_in,
  input wire logic [3*ssf_pkg::DATA_W-1:0] row_in,
  input wire logic row_valid_in,
  input wire logic draw_start_in,
  input wire logic pixel_en_in,
  input wire logic multicolor_in,
  input wire logic hdouble_in,
  input wire logic [ssf_pkg::COLOR_W-1:0] own_color_in,
  input wire logic [ssf_pkg::COLOR_W-1:0] shared0_in,
  input wire logic [ssf_pkg::COLOR_W-1:0] shared1_in,
  output logic visible_out,
  output logic [ssf_pkg::COLOR_W-1:0] color_out
);
  import ssf_pkg::*;

  typedef struct packed {
    logic [3*DATA_W-1:0] held;
    logic armed;
    logic [3*DATA_W-1:0] sh;
    logic active;
    logic [4:0] dots;
    logic [1:0] phase;
    logic visible;
    logic [COLOR_W-1:0] color;
  } ssf_shift_state_t;

  ssf_shift_state_t st;
  ssf_shift_state_t next_st;

  always_comb begin
    logic [1:0] code;
    logic [1:0] last_phase;
    code = CODE_CLEAR;
    last_phase = 2'h0;
    next_st = st;
    if (load_in) begin
      next_st.held = row_in;
      next_st.armed = row_valid_in;
    end
    // each dot lasts 1, 2 or 4 pixels; same bits reused, no new detail
    last_phase = {multicolor_in & hdouble_in, multicolor_in | hdouble_in}; // [R13] [R15]
    if (multicolor_in) begin
      code = st.sh[3*DATA_W-1 -: 2]; // [R3] [R11]
    end else begin
      code = st.sh[3*DATA_W-1] ? CODE_OWN : CODE_CLEAR; // [R2]
    end
    if (draw_start_in) begin
      next_st.sh = st.held;
      next_st.active = st.armed;
      next_st.dots = multicolor_in ? MC_DOTS : SC_DOTS; // [R3]
      next_st.phase = 2'h0;
      next_st.visible = 1'b0;
    end else if (pixel_en_in) begin
      next_st.visible = st.active && (code != CODE_CLEAR); // [R2] [R11]
      case (code)
        CODE_SHARED0: next_st.color = shared0_in; // [R11]
        CODE_OWN: next_st.color = own_color_in; // [R10]
        CODE_SHARED1: next_st.color = shared1_in; // [R11]
        default: next_st.color = st.color;
      endcase
      if (st.active) begin
        if (st.phase == last_phase) begin
          next_st.phase = 2'h0;
          next_st.sh = multicolor_in ? {st.sh[3*DATA_W-3:0], 2'h0} : {st.sh[3*DATA_W-2:0], 1'b0};
          next_st.dots = st.dots - 5'h1;
          if (st.dots == 5'h1) begin
            next_st.active = 1'b0;
          end
        end else begin
          next_st.phase = st.phase + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign visible_out = st.visible;
  assign color_out = st.color;
endmodule

/* File: ssf_top.sv */
`timescale 1ns/1ps
// Functional notes
// [R1] shape is 21 rows of three bytes
// [R2] single-color: one bit own color, zero clear
// [R3] multicolor: 12 double-wide dots, two-bit code
// [R4] 64-byte block, only 63 bytes fetched
// [R5] pointers in last eight bytes of screen
// [R6] shape start is pointer times 64
// [R7] addresses inside selected 16K bank
// [R8] banks 0 and 2 see character ROM
// [R9] enable bit n shows sprite n
// [R10] own 16-color register per sprite
// [R11] bit pairs: clear, shared0, own, shared1
// [R12] multicolor select bit per sprite
// [R13] horizontal doubling bit widens dots
// [R14] vertical doubling bit repeats each row
// [R15] doubling reuses bits, adds no detail
// [R16] eight sprites, indices 0 to 7
// [R17] attribute registers read back last write
// [R18] software keeps shapes aligned, in RAM
module ssf_top (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [ssf_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [ssf_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [ssf_pkg::DATA_W-1:0] reg_rdata_out,
  output logic [ssf_pkg::ADDR_W-1:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_rom_sel_out,
  input wire logic [ssf_pkg::DATA_W-1:0] mem_data_in,
  input wire logic line_start_in,
  input wire logic [ssf_pkg::NUM_SPR-1:0] row_restart_in,
  input wire logic draw_start_in,
  input wire logic pixel_en_in,
  output logic fetch_busy_out,
  output logic [ssf_pkg::NUM_SPR-1:0] spr_visible_out,
  output logic [ssf_pkg::NUM_SPR*ssf_pkg::COLOR_W-1:0] spr_color_out
);
  import ssf_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [NUM_SPR-1:0] enable;
    logic [NUM_SPR-1:0] vdouble;
    logic [NUM_SPR-1:0] mcselect;
    logic [NUM_SPR-1:0] hdouble;
    logic [COLOR_W-1:0] shared0;
    logic [COLOR_W-1:0] shared1;
    logic [NUM_SPR-1:0][COLOR_W-1:0] color;
    logic [3:0] screen;
    logic [1:0] bank;
    logic [DATA_W-1:0] rdata;
    ssf_fetch_state_t fstate;
    logic [SPR_W-1:0] sprite_index;
    logic [1:0] byte_idx;
    logic [DATA_W-1:0] ptr;
    logic [NUM_SPR-1:0][ROW_W-1:0] row;
    logic [NUM_SPR-1:0] half;
    logic [NUM_SPR-1:0] fetched;
    logic [NUM_SPR-1:0] row_valid;
    logic [ADDR_W-1:0] mem_addr;
    logic mem_rd;
    logic rom_sel;
    logic busy;
    logic [NUM_SPR-1:0] visible;
    logic [NUM_SPR*COLOR_W-1:0] pix;
  } ssf_top_state_t;

  ssf_top_state_t st;
  ssf_top_state_t next_st;

  logic [3*DATA_W-1:0] buf_row;
  logic [NUM_SPR-1:0] sh_visible;
  logic [NUM_SPR*COLOR_W-1:0] sh_color;
  logic buf_we;
  logic buf_re;
  logic [NUM_SPR-1:0] load_pulse;

  // ****************************************************************
  // buffer and shifter strobes
  // ****************************************************************
  always_comb begin
    buf_we = (st.fstate == FS_DATA_WAIT);
    buf_re = (st.fstate == FS_LOAD_RD);
    load_pulse = '0;
    if (st.fstate == FS_LOAD_WR) begin
      load_pulse[st.sprite_index] = 1'b1;
    end
  end

  ssf_line_buf u_line_buf (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(buf_we),
    .wr_spr_in(st.sprite_index),
    .wr_byte_in(st.byte_idx),
    .wr_data_in(mem_data_in),
    .rd_en_in(buf_re),
    .rd_spr_in(st.sprite_index),
    .rd_row_out(buf_row)
  );

  // ****************************************************************
  // eight dot shifters
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SPR; gi++) begin : g_spr // [R16]
      ssf_dot_shifter u_shifter (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .load_in(load_pulse[gi]),
        .row_in(buf_row),
        .row_valid_in(st.row_valid[gi]),
        .draw_start_in(draw_start_in),
        .pixel_en_in(pixel_en_in),
        .multicolor_in(st.mcselect[gi]), // [R12]
        .hdouble_in(st.hdouble[gi]), // [R13]
        .own_color_in(st.color[gi]),
        .shared0_in(st.shared0),
        .shared1_in(st.shared1),
        .visible_out(sh_visible[gi]),
        .color_out(sh_color[gi*COLOR_W +: COLOR_W])
      );
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [ADDR_W-1:0] bank_base;
    logic [ADDR_W-1:0] fetch_addr;
    logic [6:0] row_ofs;
    logic go_next;
    bank_base = '0;
    fetch_addr = '0;
    row_ofs = '0;
    go_next = 1'b0;
    next_st = st;
    next_st.mem_rd = 1'b0;

    // register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        REG_ENABLE: next_st.enable = reg_wdata_in; // [R9]
        REG_VDOUBLE: next_st.vdouble = reg_wdata_in; // [R14]
        REG_MCSELECT: next_st.mcselect = reg_wdata_in; // [R12]
        REG_HDOUBLE: next_st.hdouble = reg_wdata_in; // [R13]
        REG_SHARED0: next_st.shared0 = reg_wdata_in[COLOR_W-1:0]; // [R11]
        REG_SHARED1: next_st.shared1 = reg_wdata_in[COLOR_W-1:0]; // [R11]
        REG_SCREEN: next_st.screen = reg_wdata_in[3:0]; // [R5]
        REG_BANK: next_st.bank = reg_wdata_in[1:0]; // [R7]
        default: begin
          if (reg_addr_in >= REG_COLOR_BASE && reg_addr_in < REG_COLOR_BASE + 16'h8) begin
            next_st.color[reg_addr_in[SPR_W-1:0] - REG_COLOR_BASE[SPR_W-1:0]] = reg_wdata_in[COLOR_W-1:0]; // [R10]
          end
        end
      endcase
    end

    // register reads, unmapped reads zero
    next_st.rdata = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_ENABLE: next_st.rdata = st.enable; // [R17]
        REG_VDOUBLE: next_st.rdata = st.vdouble; // [R17]
        REG_MCSELECT: next_st.rdata = st.mcselect; // [R17]
        REG_HDOUBLE: next_st.rdata = st.hdouble; // [R17]
        REG_SHARED0: next_st.rdata = {4'h0, st.shared0};
        REG_SHARED1: next_st.rdata = {4'h0, st.shared1};
        REG_SCREEN: next_st.rdata = {4'h0, st.screen};
        REG_BANK: next_st.rdata = {6'h0, st.bank};
        REG_STATUS: next_st.rdata = {st.busy, 4'h0, st.sprite_index};
        default: begin
          if (reg_addr_in >= REG_COLOR_BASE && reg_addr_in < REG_COLOR_BASE + 16'h8) begin
            next_st.rdata = {4'h0, st.color[reg_addr_in[SPR_W-1:0] - REG_COLOR_BASE[SPR_W-1:0]]}; // [R17]
          end
        end
      endcase
    end

    // fetch addresses
    bank_base = {st.bank, {BANK_SHIFT{1'b0}}}; // [R7]
    row_ofs = 7'(st.row[st.sprite_index]) * 7'h3 + 7'(st.byte_idx); // [R1] [R4]
    if (st.fstate == FS_PTR) begin
      // pointer area follows the screen base
      fetch_addr = bank_base | {2'h0, st.screen, PTR_AREA_OFS | {7'h0, st.sprite_index}}; // [R5]
    end else begin
      fetch_addr = bank_base | {2'h0, st.ptr, {BLOCK_SHIFT{1'b0}}} | {9'h0, row_ofs}; // [R6]
    end

    // fetch sequencer
    case (st.fstate)
      FS_IDLE: begin
        if (line_start_in) begin
          next_st.fstate = FS_PTR;
          next_st.sprite_index = '0;
          next_st.busy = 1'b1;
          next_st.fetched = '0;
        end
      end
      FS_PTR: begin
        if (st.enable[st.sprite_index] && st.row[st.sprite_index] < SPR_ROWS) begin // [R9] [R1]
          next_st.mem_addr = fetch_addr;
          next_st.mem_rd = 1'b1;
          next_st.rom_sel = !st.bank[0] && fetch_addr[13:12] == ROM_WINDOW; // [R8]
          next_st.fstate = FS_PTR_WAIT;
        end else begin
          go_next = 1'b1;
        end
      end
      FS_PTR_WAIT: begin
        next_st.ptr = mem_data_in; // [R6]
        next_st.byte_idx = 2'h0;
        next_st.fstate = FS_DATA;
      end
      FS_DATA: begin
        next_st.mem_addr = fetch_addr;
        next_st.mem_rd = 1'b1;
        next_st.rom_sel = !st.bank[0] && fetch_addr[13:12] == ROM_WINDOW; // [R8]
        next_st.fstate = FS_DATA_WAIT;
      end
      FS_DATA_WAIT: begin
        if (st.byte_idx == 2'h2) begin
          next_st.fetched[st.sprite_index] = 1'b1;
          // repeat the row on a second line when doubled
          if (st.vdouble[st.sprite_index] && !st.half[st.sprite_index]) begin // [R14] [R15]
            next_st.half[st.sprite_index] = 1'b1;
          end else begin
            next_st.half[st.sprite_index] = 1'b0;
            next_st.row[st.sprite_index] = st.row[st.sprite_index] + 5'h1; // [R1]
          end
          go_next = 1'b1;
        end else begin
          next_st.byte_idx = st.byte_idx + 2'h1;
          next_st.fstate = FS_DATA;
        end
      end
      FS_LOAD_RD: begin
        next_st.fstate = FS_LOAD_WR;
      end
      FS_LOAD_WR: begin
        if (st.sprite_index == 3'h7) begin
          next_st.fstate = FS_IDLE;
          next_st.busy = 1'b0;
        end else begin
          next_st.sprite_index = st.sprite_index + 3'h1;
          next_st.fstate = FS_LOAD_RD;
        end
      end
      default: next_st.fstate = FS_IDLE;
    endcase

    if (go_next) begin
      if (st.sprite_index == 3'h7) begin
        next_st.sprite_index = '0;
        next_st.fstate = FS_LOAD_RD;
        next_st.row_valid = next_st.fetched;
      end else begin
        next_st.sprite_index = st.sprite_index + 3'h1;
        next_st.fstate = FS_PTR;
      end
    end

    // external row restart wins over the advance
    for (int i = 0; i < NUM_SPR; i++) begin
      if (row_restart_in[i]) begin
        next_st.row[i] = '0;
        next_st.half[i] = 1'b0;
      end
    end

    // registered pixel outputs
    next_st.visible = sh_visible;
    next_st.pix = sh_color;
  end

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '0;
      st.enable <= RST_BITS;
      st.vdouble <= RST_BITS;
      st.mcselect <= RST_BITS;
      st.hdouble <= RST_BITS;
      st.shared0 <= RST_COLOR;
      st.shared1 <= RST_COLOR;
      st.screen <= RST_SCREEN;
      st.bank <= RST_BANK;
      st.fstate <= FS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reg_rdata_out = st.rdata;
  assign mem_addr_out = st.mem_addr;
  assign mem_rd_out = st.mem_rd;
  assign mem_rom_sel_out = st.rom_sel;
  assign fetch_busy_out = st.busy;
  assign spr_visible_out = st.visible;
  assign spr_color_out = st.pix;
endmodule

/* File: ssf_assertions.sv */
`timescale 1ns/1ps
// ****************************************************************
// port checker of the sprite shape fetch block
// ****************************************************************
module ssf_assertions (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic [ssf_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [ssf_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [ssf_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic [ssf_pkg::ADDR_W-1:0] mem_addr_out,
  input wire logic mem_rd_out,
  input wire logic mem_rom_sel_out,
  input wire logic [ssf_pkg::DATA_W-1:0] mem_data_in,
  input wire logic line_start_in,
  input wire logic draw_start_in,
  input wire logic pixel_en_in,
  input wire logic fetch_busy_out,
  input wire logic [ssf_pkg::NUM_SPR-1:0] spr_visible_out,
  input wire logic [ssf_pkg::NUM_SPR*ssf_pkg::COLOR_W-1:0] spr_color_out
);
  import ssf_pkg::*;
  logic [3:0] scr_q;
  logic [1:0] bank_q;
  logic ptr_area;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);
  // ****************************************************************
  // shadow of screen base and bank
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scr_q <= RST_SCREEN;
      bank_q <= RST_BANK;
    end else if (reg_wr_in) begin
      if (reg_addr_in == REG_SCREEN) scr_q <= reg_wdata_in[3:0];
      if (reg_addr_in == REG_BANK) bank_q <= reg_wdata_in[1:0];
    end
  end
  assign ptr_area = mem_addr_out[13:3] == {scr_q, 7'h7f};
  // ****************************************************************
  // properties
  // ****************************************************************
  chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read slot");
  chk_rd_pulse: assert property (mem_rd_out |=> !mem_rd_out)
    else $error("memory read longer than one cycle");
  chk_rd_busy: assert property (mem_rd_out |-> fetch_busy_out)
    else $error("memory read while not busy");
  chk_bank_addr: assert property (mem_rd_out |-> mem_addr_out[15:14] == bank_q)
    else $error("read outside selected bank");
  chk_rom_flag: assert property (mem_rd_out |-> mem_rom_sel_out == (!mem_addr_out[14] && mem_addr_out[13:12] == 2'h1))
    else $error("rom flag wrong");
  chk_no_pad_byte: assert property (mem_rd_out && !ptr_area |-> mem_addr_out[5:0] != 6'h3f)
    else $error("last byte of block fetched");
  chk_ptr_scale: assert property (mem_rd_out && ptr_area |-> ##2 mem_rd_out && mem_addr_out[13:6] == $past(mem_data_in, 2))
    else $error("shape start not pointer times 64");
  chk_row_bytes: assert property (mem_rd_out && !ptr_area && mem_addr_out[5:0] % 6'd3 != 6'd2
    |-> ##2 mem_rd_out && mem_addr_out == $past(mem_addr_out, 2) + 16'h1)
    else $error("row bytes not consecutive");
  chk_busy_start: assert property ((!line_start_in && !fetch_busy_out) [*2] |=> !fetch_busy_out)
    else $error("busy without line start");
  chk_dot_hold: assert property (!pixel_en_in && !draw_start_in |-> ##2 $stable(spr_visible_out) && $stable(spr_color_out))
    else $error("dot output changed without pixel");
endmodule

bind ssf_top ssf_assertions i_chk (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .mem_addr_out(mem_addr_out),
  .mem_rd_out(mem_rd_out), .mem_rom_sel_out(mem_rom_sel_out), .mem_data_in(mem_data_in),
  .line_start_in(line_start_in), .draw_start_in(draw_start_in), .pixel_en_in(pixel_en_in),
  .fetch_busy_out(fetch_busy_out), .spr_visible_out(spr_visible_out), .spr_color_out(spr_color_out)
);

/* File: ssf_mem_model.sv */
`timescale 1ns/1ps
// ****************************************************************
// video memory, data valid while the read request stands
// ****************************************************************
module ssf_mem_model (
  input wire logic clk_sys_in,
  input wire logic [ssf_pkg::ADDR_W-1:0] mem_addr_in,
  input wire logic mem_rd_in,
  output logic [ssf_pkg::DATA_W-1:0] mem_data_out
);
  import ssf_pkg::*;
  logic [DATA_W-1:0] mem [0:65535];
  logic [DATA_W-1:0] held = 8'h00;
  // stale data inverted each cycle outside a request
  always @(posedge clk_sys_in) held <= mem_data_out;
  assign mem_data_out = mem_rd_in ? mem[mem_addr_in] : ~held;
endmodule

/* File: ssf_top_tb_top.sv */
`timescale 1ns/1ps
module ssf_top_tb_top;
  import ssf_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] rdata;
  logic [15:0] mem_addr;
  logic mem_rd;
  logic [7:0] mem_data;
  logic line_start = 1'b0;
  logic [7:0] row_restart = 8'h00;
  logic draw_start = 1'b0;
  logic pixel_en = 1'b0;
  logic busy;
  logic [7:0] vis;
  logic [31:0] color;
  int err_count = 0;
  int check_count = 0;
  int rd_cnt = 0;
  logic [31:0] seed = 32'h9011a7cc;
  logic [7:0] cfg [14];
  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (mem_rd === 1'b1) rd_cnt++;
  ssf_top i_dut (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .mem_addr_out(mem_addr), .mem_rd_out(mem_rd),
    .mem_rom_sel_out(), .mem_data_in(mem_data), .line_start_in(line_start), .row_restart_in(row_restart),
    .draw_start_in(draw_start), .pixel_en_in(pixel_en), .fetch_busy_out(busy), .spr_visible_out(vis),
    .spr_color_out(color)
  );
  ssf_mem_model i_mem (.clk_sys_in(clk_sys_in), .mem_addr_in(mem_addr), .mem_rd_in(mem_rd), .mem_data_out(mem_data));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] raddr(input int i);
    logic [15:0] t [6] = '{REG_ENABLE, REG_VDOUBLE, REG_MCSELECT, REG_HDOUBLE, REG_SHARED0, REG_SHARED1};
    return i < 6 ? t[i] : REG_COLOR_BASE + 16'(i - 6);
  endfunction
  function automatic logic [4:0] dot(input logic [23:0] r, input logic mc, input logic hd, input logic [3:0] own,
                                     input int p);
    int d;
    logic [1:0] c;
    d = p / ((mc ? 2 : 1) * (hd ? 2 : 1));
    c = mc ? (d < 12 ? r[23 - 2 * d -: 2] : 2'h0) : (d < 24 ? {r[23 - d], 1'b0} : 2'h0);
    case (c)
      CODE_SHARED0: return {1'b1, cfg[4][3:0]};
      CODE_OWN: return {1'b1, own};
      CODE_SHARED1: return {1'b1, cfg[5][3:0]};
      default: return 5'h00;
    endcase
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rcheck(input logic [15:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd <= 1'b0;
    @(negedge clk_sys_in);
    check($sformatf("reg %h", a), {24'h0, rdata}, {24'h0, exp});
    @(posedge clk_sys_in);
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 400 && busy === 1'b1; i++) @(posedge clk_sys_in);
    if (i == 400) begin
      err_count++;
      $display("MISMATCH busy expected 0 seen 1");
      end_of_test();
    end
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [7:0] v;
    logic [15:0] base;
    logic [15:0] a;
    logic [23:0] row;
    logic [31:0] ev;
    logic [31:0] ec;
    logic [31:0] em;
    logic [3:0] scr;
    logic [1:0] bank;
    logic [4:0] dt;
    for (int k = 0; k < 65536; k++) i_mem.mem[k] = 8'(rnd());
    repeat (8) @(posedge clk_sys_in);
    rst_b_in <= 1'b1;
    @(posedge clk_sys_in);
    for (int i = 0; i < 14; i++) rcheck(raddr(i), RST_BITS);
    rcheck(REG_SCREEN, {4'h0, RST_SCREEN});
    rcheck(REG_BANK, {6'h0, RST_BANK});
    rcheck(16'hd030, 8'h00);
    $display("test reset values done");
    for (int run = 0; run < 2; run++) begin
      for (int i = 0; i < 14; i++) cfg[i] = i < 4 ? 8'(rnd()) : 8'(rnd()) & 8'h0f;
      cfg[0] = (cfg[0] | 8'h81) & 8'hef;
      for (int i = 0; i < 14; i++) wr(raddr(i), cfg[i]);
      for (int i = 0; i < 14; i++) rcheck(raddr(i), cfg[i]);
      row_restart <= 8'hff;
      @(posedge clk_sys_in);
      row_restart <= 8'h00;
      for (int ln = 0; ln < 4; ln++) begin
        bank = ln == 3 ? 2'h0 : {1'(rnd()), 1'b1};
        scr = ln == 3 ? 4'h4 : 4'(rnd());
        wr(REG_SCREEN, {4'h0, scr});
        wr(REG_BANK, {6'h0, bank});
        base = {bank, 14'h0};
        for (int n = 0; n < 8; n++) begin
          v = 8'(rnd());
          if (!bank[0] && v[7:6] == 2'h1) v[7] = 1'b1;
          if (v == {scr, 4'hf}) v[0] = 1'b0;
          i_mem.mem[base + {2'h0, scr, 10'h3f8} + 16'(n)] = v;
        end
        rd_cnt = 0;
        line_start <= 1'b1;
        @(posedge clk_sys_in);
        line_start <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        line_start <= 1'b1;
        @(posedge clk_sys_in);
        line_start <= 1'b0;
        wait_idle();
        check("reads", 32'(rd_cnt), 32'(4 * $countones(cfg[0])));
        draw_start <= 1'b1;
        @(posedge clk_sys_in);
        draw_start <= 1'b0;
        for (int p = 0; p < 50; p++) begin
          pixel_en <= 1'b1;
          @(posedge clk_sys_in);
          pixel_en <= 1'b0;
          repeat (2) @(posedge clk_sys_in);
          @(negedge clk_sys_in);
          ev = 32'h0;
          ec = 32'h0;
          em = 32'h0;
          for (int n = 0; n < 8; n++) begin
            v = i_mem.mem[base + {2'h0, scr, 10'h3f8} + 16'(n)];
            a = base + {v, 6'h0} + 16'((cfg[1][n] ? ln / 2 : ln) * 3);
            row = {i_mem.mem[a], i_mem.mem[a + 16'h1], i_mem.mem[a + 16'h2]};
            dt = cfg[0][n] ? dot(row, cfg[2][n], cfg[3][n], cfg[6 + n][3:0], p) : 5'h00;
            ev[n] = dt[4];
            em[4 * n +: 4] = {4{dt[4]}};
            ec[4 * n +: 4] = dt[3:0];
          end
          check("visible", {24'h0, vis}, ev);
          check("color", color & em, ec);
          @(posedge clk_sys_in);
        end
      end
      $display("test fetch and draw run %0d done", run);
    end
    end_of_test();
  end
endmodule
